// ### ilp_pkg.sv
// constants, register map and encodings of the io-link port data block
// assumes one pclk domain shared with the fieldbus and link engines
`default_nettype none
package ilp_pkg;
	////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CYCLE = 8'h04;
	localparam logic [7:0] ADDR_VENDOR = 8'h08;
	localparam logic [7:0] ADDR_DEVICE = 8'h0c;
	localparam logic [7:0] ADDR_SIZE = 8'h10;
	localparam logic [7:0] ADDR_LIMIT = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;
	localparam logic [7:0] ADDR_DSCK = 8'h1c;
	// field positions
	localparam int CTRL_FS = 0;
	localparam int CTRL_SW = 2;
	localparam int CTRL_MODE = 4;
	localparam int CTRL_VAL = 8;
	localparam int SIZE_MAP = 8;
	localparam int LIMIT_PORT = 16;
	localparam int ST_RUN = 16;
	localparam int ST_DSV = 17;
	localparam int ST_POV = 18;
	localparam int ST_CMD = 20;
	// reset values
	localparam logic [15:0] VENDOR_RST = 16'h0001;
	localparam logic [23:0] DEVICE_RST = 24'h000001;
	localparam logic [4:0] SIZE_RST = 5'h10;
	localparam logic [10:0] MIN_RST = 11'h004;
	// cycle times counted in ticks of 100 us
	localparam int TICK_US = 100;
	localparam logic [10:0] CYC_LOW = 11'h004;
	localparam logic [10:0] CYC_BASE1 = 11'h040;
	localparam logic [10:0] CYC_BASE2 = 11'h140;
	localparam logic [10:0] CYC_MAX = 11'h530;
	localparam logic [7:0] CODE_AUTO = 8'h00;
	////////////////////////////////////////////////////////////////////////
	typedef enum logic [1:0] {FS_CLEAR_VALID = 2'h0, FS_HOLD = 2'h1, FS_CLEAR_INVALID = 2'h2} ilp_fs_e;
	typedef enum logic [1:0] {SW_DIRECT = 2'h0, SW_16 = 2'h1, SW_32 = 2'h2, SW_ALL = 2'h3} ilp_sw_e;
	typedef enum logic [2:0] {MD_OFF = 3'h0, MD_MANUAL = 3'h1, MD_AUTO = 3'h2, MD_DI = 3'h3, MD_DO = 3'h4} ilp_md_e;
	typedef enum logic [2:0] {VL_NOCHECK = 3'h0, VL_V10 = 3'h1, VL_V11 = 3'h2, VL_BR = 3'h3, VL_R = 3'h4} ilp_vl_e;
	typedef enum logic [1:0] {DS_NONE = 2'h0, DS_BACKUP = 2'h1, DS_RESTORE = 2'h2, DS_CLEAR = 2'h3} ilp_ds_e;
	typedef enum logic [1:0] {PH_IDLE = 2'h0, PH_RUN = 2'h1} ilp_ph_e;
	localparam logic [1:0] TB_00 = 2'h0;
	localparam logic [1:0] TB_01 = 2'h1;
	localparam logic [1:0] TB_10 = 2'h2;
endpackage
`default_nettype wire

// ### ilp_port.sv
// one io-link port: failsafe outputs, byte swap, cycle decode, parameter storage
// assumes apb master on pclk; link and fieldbus signals are on pclk too
`default_nettype none
module ilp_port
	import ilp_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic upstream_ok,
	input wire logic [127:0] up_process_output_valid,
	input wire logic [127:0] dev_pd_in,
	input wire logic port_start,
	input wire logic port_stop,
	input wire logic dev_backup_req,
	input wire logic [15:0] dev_checksum,
	output logic [127:0] port_process_output_valid,
	output logic process_output_valid,
	output logic [127:0] map_pd_in,
	output logic [10:0] cycle_time,
	output logic [1:0] ds_cmd,
	output logic ds_cmd_stb
);
	import ilp_pkg::*;

	typedef struct packed {
		ilp_ph_e ph;
		logic [1:0] fs;
		logic [1:0] sw;
		logic [2:0] mode;
		logic [2:0] val;
		logic [7:0] code;
		logic [15:0] vid;
		logic [23:0] did;
		logic [4:0] dsz;
		logic [4:0] msz;
		logic [10:0] dmin;
		logic [10:0] pmin;
		logic [1:0] a_fs;
		logic [1:0] a_sw;
		logic [4:0] a_dsz;
		logic [4:0] a_msz;
		logic [10:0] cyc;
		logic ds_valid;
		logic [15:0] ds_ck;
		logic [1:0] cmd;
		logic stb;
		logic [1:0] last_cmd;
		logic [127:0] po;
		logic po_valid;
		logic [127:0] map;
		logic [31:0] rdata;
		logic err;
	} ilp_state_s;

	ilp_state_s st_r;
	ilp_state_s st_nxt;
	logic wr;
	logic setup;
	logic [10:0] req_cyc;
	logic [10:0] fix_cyc;
	logic [1:0] ds_dec;

	////////////////////////////////////////////////////////////////////////
	// byte mapping of device data into the mapping area, byte 0 in bits 7:0
	function automatic logic [127:0] map_bytes(input logic [127:0] src, input logic [1:0] sw,
		input logic [4:0] dsz, input logic [4:0] msz);
		logic [127:0] r;
		logic [4:0] j;
		logic [4:0] k;
		r = '0;
		for (int i = 0; i < 16; i++)
		begin
			k = 5'(i);
			j = k;
			case (sw)
				SW_16: j = k ^ 5'h01;
				SW_32: if (msz != 5'h02 && (k | 5'h03) < msz) j = k ^ 5'h03;
				SW_ALL: j = msz - 5'h01 - k;
				default: j = k;
			endcase
			// padding bytes below msz travel as zeros through the swap
			if (k < msz && j < dsz) r[i*8 +: 8] = src[int'(j)*8 +: 8];
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// cycle time decode, in 100 us ticks
	always_comb
	begin
		case (st_r.code[7:6])
			TB_00: req_cyc = (st_r.code[5:0] < 6'h04) ? CYC_LOW : {5'h00, st_r.code[5:0]};
			TB_01: req_cyc = CYC_BASE1 + {3'h0, st_r.code[5:0], 2'h0};
			TB_10: req_cyc = CYC_BASE2 + {1'h0, st_r.code[5:0], 4'h0};
			default: req_cyc = CYC_MAX;
		endcase
		if (st_r.code == CODE_AUTO) req_cyc = st_r.dmin;
		// the link cannot go faster than the port itself allows
		fix_cyc = (req_cyc < st_r.pmin) ? st_r.pmin : req_cyc;
	end

	// storage decision taken at start-up
	always_comb
	begin
		ds_dec = DS_NONE;
		if (st_r.val == VL_NOCHECK || st_r.val == VL_V10 || st_r.val == VL_V11)
			ds_dec = DS_CLEAR;
		else if (st_r.mode != MD_MANUAL)
			ds_dec = DS_NONE;
		else if (st_r.val == VL_BR)
		begin
			if (!st_r.ds_valid || dev_backup_req)
				ds_dec = DS_BACKUP;
			else if (dev_checksum != st_r.ds_ck)
				ds_dec = DS_RESTORE;
		end
		else if (st_r.val == VL_R)
		begin
			if (st_r.ds_valid && !dev_backup_req && dev_checksum != st_r.ds_ck)
				ds_dec = DS_RESTORE;
		end
	end

	assign setup = psel && !penable;
	assign wr = psel && penable && pwrite;

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.stb = 1'b0;
		// read data and error are latched in the setup cycle, so no wait state
		if (setup)
		begin
			st_nxt.err = 1'b0;
			case (paddr)
				ADDR_CTRL: st_nxt.rdata = 32'(st_r.fs) << CTRL_FS | 32'(st_r.sw) << CTRL_SW
					| 32'(st_r.mode) << CTRL_MODE | 32'(st_r.val) << CTRL_VAL;
				ADDR_CYCLE: st_nxt.rdata = 32'(st_r.code);
				ADDR_VENDOR: st_nxt.rdata = 32'(st_r.vid);
				ADDR_DEVICE: st_nxt.rdata = 32'(st_r.did);
				ADDR_SIZE: st_nxt.rdata = 32'(st_r.dsz) | 32'(st_r.msz) << SIZE_MAP;
				ADDR_LIMIT: st_nxt.rdata = 32'(st_r.dmin) | 32'(st_r.pmin) << LIMIT_PORT;
				ADDR_STATUS: st_nxt.rdata = 32'(st_r.cyc) | 32'(st_r.ph == PH_RUN) << ST_RUN
					| 32'(st_r.ds_valid) << ST_DSV | 32'(st_r.po_valid) << ST_POV | 32'(st_r.last_cmd) << ST_CMD;
				ADDR_DSCK: st_nxt.rdata = 32'(st_r.ds_ck);
				default:
				begin
					st_nxt.rdata = '0;
					st_nxt.err = 1'b1;
				end
			endcase
		end
		// writes land in the holding registers; the port sees them at start-up, but a vendor or device id change clears ds_valid at once
		if (wr)
		begin
			case (paddr)
				ADDR_CTRL:
				begin
					st_nxt.fs = pwdata[CTRL_FS +: 2];
					st_nxt.sw = pwdata[CTRL_SW +: 2];
					st_nxt.mode = pwdata[CTRL_MODE +: 3];
					st_nxt.val = (pwdata[CTRL_MODE +: 3] != MD_MANUAL) ? VL_NOCHECK : pwdata[CTRL_VAL +: 3];
				end
				ADDR_CYCLE: st_nxt.code = pwdata[7:0];
				ADDR_VENDOR:
				begin
					st_nxt.vid = pwdata[15:0];
					if (pwdata[15:0] != st_r.vid) st_nxt.ds_valid = 1'b0;
				end
				ADDR_DEVICE:
				begin
					st_nxt.did = pwdata[23:0];
					if (pwdata[23:0] != st_r.did) st_nxt.ds_valid = 1'b0;
				end
				ADDR_SIZE:
				begin
					st_nxt.dsz = pwdata[4:0];
					st_nxt.msz = pwdata[SIZE_MAP +: 5];
				end
				ADDR_LIMIT:
				begin
					st_nxt.dmin = pwdata[10:0];
					st_nxt.pmin = pwdata[LIMIT_PORT +: 11];
				end
				default: st_nxt.err = st_r.err;
			endcase
		end
		// port phase
		case (st_r.ph)
			PH_IDLE:
			begin
				if (port_start)
					st_nxt.ph = PH_RUN;
			end
			PH_RUN:
			begin
				if (port_stop && !port_start)
					st_nxt.ph = PH_IDLE;
			end
			default: st_nxt.ph = PH_IDLE;
		endcase
		if (port_start)
		begin
			st_nxt.a_fs = st_r.fs;
			st_nxt.a_sw = st_r.sw;
			st_nxt.a_dsz = st_r.dsz;
			st_nxt.a_msz = st_r.msz;
			st_nxt.cyc = fix_cyc;
			st_nxt.cmd = ds_dec;
			st_nxt.stb = 1'b1;
			st_nxt.last_cmd = ds_dec;
			// a start-up backup wins over an id clear in the same cycle
			if (ds_dec == DS_BACKUP)
			begin
				st_nxt.ds_valid = 1'b1;
				st_nxt.ds_ck = dev_checksum;
			end
			else if (ds_dec == DS_CLEAR)
				st_nxt.ds_valid = 1'b0;
		end
		// output side toward the device
		if (st_r.ph != PH_RUN)
		begin
			st_nxt.po = '0;
			st_nxt.po_valid = 1'b0;
			st_nxt.map = '0;
		end
		else
		begin
			st_nxt.map = map_bytes(dev_pd_in, st_r.a_sw, st_r.a_dsz, st_r.a_msz);
			if (upstream_ok)
			begin
				st_nxt.po = up_process_output_valid;
				st_nxt.po_valid = 1'b1;
			end
			else
			begin
				case (st_r.a_fs)
					FS_HOLD: st_nxt.po_valid = 1'b1;
					FS_CLEAR_INVALID:
					begin
						st_nxt.po = '0;
						st_nxt.po_valid = 1'b0;
					end
					default:
					begin
						st_nxt.po = '0;
						st_nxt.po_valid = 1'b1;
					end
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_r <= '0;
			st_r.mode <= MD_MANUAL;
			st_r.vid <= VENDOR_RST;
			st_r.did <= DEVICE_RST;
			st_r.dsz <= SIZE_RST;
			st_r.msz <= SIZE_RST;
			st_r.a_dsz <= SIZE_RST;
			st_r.a_msz <= SIZE_RST;
			st_r.dmin <= MIN_RST;
			st_r.pmin <= MIN_RST;
			st_r.cyc <= MIN_RST;
		end
		else
			st_r <= st_nxt;
	end

	assign prdata = st_r.rdata;
	assign pready = psel && penable;
	assign pslverr = st_r.err;
	assign port_process_output_valid = st_r.po;
	assign process_output_valid = st_r.po_valid;
	assign map_pd_in = st_r.map;
	assign cycle_time = st_r.cyc;
	assign ds_cmd = st_r.cmd;
	assign ds_cmd_stb = st_r.stb;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_fs_clear;
		st_r.ph == PH_RUN && !port_start && st_r.a_fs == FS_CLEAR_VALID && !upstream_ok
			|=> port_process_output_valid == '0 && process_output_valid;
	endproperty
	a_fs_clear: assert property (p_fs_clear) else $error("clear-valid failsafe wrong");

	property p_fs_hold;
		st_r.ph == PH_RUN && st_r.a_fs == FS_HOLD && !upstream_ok
			|=> port_process_output_valid == $past(port_process_output_valid) && process_output_valid;
	endproperty
	a_fs_hold: assert property (p_fs_hold) else $error("hold failsafe lost output");

	property p_fs_inv;
		st_r.ph == PH_RUN && st_r.a_fs == FS_CLEAR_INVALID && !upstream_ok
			|=> port_process_output_valid == '0 && !process_output_valid;
	endproperty
	a_fs_inv: assert property (p_fs_inv) else $error("clear-invalid failsafe wrong");

	property p_swap_all;
		st_r.ph == PH_RUN && st_r.a_sw == SW_ALL && st_r.a_msz == 5'h10 && st_r.a_dsz != 5'h00
			|=> map_pd_in[127:120] == $past(dev_pd_in[7:0]);
	endproperty
	a_swap_all: assert property (p_swap_all) else $error("swap-all last byte wrong");

	property p_swap32_two;
		st_r.ph == PH_RUN && st_r.a_sw == SW_32 && st_r.a_msz == 5'h02 && st_r.a_dsz >= 5'h02
			|=> map_pd_in == {112'h0, $past(dev_pd_in[15:0])};
	endproperty
	a_swap32_two: assert property (p_swap32_two) else $error("two-byte swap32 changed order");

	property p_cyc_floor;
		port_start |=> cycle_time >= $past(st_r.pmin);
	endproperty
	a_cyc_floor: assert property (p_cyc_floor) else $error("cycle below port minimum");

	property p_cyc_top;
		port_start && st_r.code[7:6] == 2'h3 && st_r.pmin <= CYC_MAX |=> cycle_time == CYC_MAX;
	endproperty
	a_cyc_top: assert property (p_cyc_top) else $error("top codes not 132.8 ms");

	property p_br_empty;
		port_start && st_r.mode == MD_MANUAL && st_r.val == VL_BR && !st_r.ds_valid
			|=> ds_cmd_stb && ds_cmd == DS_BACKUP ##1 st_r.ds_valid;
	endproperty
	a_br_empty: assert property (p_br_empty) else $error("empty storage not backed up");

	property p_r_empty;
		port_start && st_r.val == VL_R && !st_r.ds_valid |=> ds_cmd_stb && ds_cmd == DS_NONE;
	endproperty
	a_r_empty: assert property (p_r_empty) else $error("restore-only acted on empty storage");

	property p_id_clear;
		wr && paddr == ADDR_VENDOR && pwdata[15:0] != st_r.vid && !port_start |=> !st_r.ds_valid;
	endproperty
	a_id_clear: assert property (p_id_clear) else $error("vendor change kept storage");

	c_restore: cover property (ds_cmd_stb && ds_cmd == DS_RESTORE);
	c_hold: cover property (st_r.ph == PH_RUN && st_r.a_fs == FS_HOLD && !upstream_ok);
	c_swap16: cover property (st_r.ph == PH_RUN && st_r.a_sw == SW_16 && st_r.a_dsz < st_r.a_msz);
endmodule // ilp_port
`default_nettype wire

// ### ilp_dev_model.sv
// io-link device model: own input data, checksum and backup request
// assumes the bench sets wanted values; everything on pclk
`default_nettype none
module ilp_dev_model
#(
	parameter logic [127:0] SAFE_PD = '1
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [127:0] set_pd,
	input wire logic [15:0] set_ck,
	input wire logic set_req,
	input wire logic [127:0] port_process_output_valid,
	input wire logic process_output_valid,
	output logic [127:0] dev_pd_in,
	output logic [15:0] dev_checksum,
	output logic dev_backup_req,
	output logic [127:0] applied
);
	timeunit 1ns;
	timeprecision 1ns;
	////////////////////////////////////////////////////////////////////////
	// device updates its data just after the edge, like a real link layer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dev_pd_in <= '0;
			dev_checksum <= '0;
			dev_backup_req <= 1'b0;
			applied <= SAFE_PD;
		end
		else
		begin
			dev_pd_in <= set_pd;
			dev_checksum <= set_ck;
			dev_backup_req <= set_req;
			// invalid output: device falls back to its own safe value
			applied <= process_output_valid ? port_process_output_valid : SAFE_PD;
		end
	end
endmodule // ilp_dev_model
`default_nettype wire

// ### testbench.sv
// bench for ilp_port: apb master, fieldbus stimulus, device model
// assumes zero-wait apb and one-cycle start latency of the port
`default_nettype none
module testbench;
	import ilp_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic upstream_ok, port_start, port_stop, set_req, dev_backup_req, process_output_valid, ds_cmd_stb;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [127:0] up_process_output_valid, dev_pd_in, port_process_output_valid, map_pd_in, set_pd, applied;
	logic [15:0] set_ck, dev_checksum;
	logic [10:0] cycle_time, cur;
	logic [1:0] ds_cmd;
	int fails, n_checks;
	ilp_port u_ilp_port (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.upstream_ok(upstream_ok), .up_process_output_valid(up_process_output_valid), .dev_pd_in(dev_pd_in), .port_start(port_start),
		.port_stop(port_stop), .dev_backup_req(dev_backup_req), .dev_checksum(dev_checksum),
		.port_process_output_valid(port_process_output_valid), .process_output_valid(process_output_valid), .map_pd_in(map_pd_in),
		.cycle_time(cycle_time), .ds_cmd(ds_cmd), .ds_cmd_stb(ds_cmd_stb));
	ilp_dev_model u_ilp_dev_model (.pclk(pclk), .presetn(presetn), .set_pd(set_pd), .set_ck(set_ck),
		.set_req(set_req), .port_process_output_valid(port_process_output_valid), .process_output_valid(process_output_valid),
		.dev_pd_in(dev_pd_in), .dev_checksum(dev_checksum), .dev_backup_req(dev_backup_req), .applied(applied));
	////////////////////////////////////////////////////////////////////////
	task automatic test_done();
		if (fails == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// request held until the edge that samples pready high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (i == 20)
		begin
			fails++;
			test_done();
		end
		else
		begin
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(128'(rd), 128'(exp));
	endtask
	task automatic start(input logic [1:0] cmd);
		@(posedge pclk);
		port_start <= 1'b1;
		@(posedge pclk);
		port_start <= 1'b0;
		#1;
		chk(128'(ds_cmd_stb), 128'h1);
		chk(128'(ds_cmd), 128'(cmd));
		chk(128'(cycle_time), 128'(cur));
		repeat (2) @(posedge pclk);
		// look at outputs once the edge has settled
		#1;
	endtask
	task automatic dev(input logic [15:0] ck, input logic req);
		@(posedge pclk);
		set_ck <= ck;
		set_req <= req;
		repeat (2) @(posedge pclk);
	endtask
	function automatic logic [10:0] cyc_exp(input logic [7:0] c, input logic [10:0] dmin, input logic [10:0] pmin);
		logic [10:0] t;
		case (c[7:6])
			2'h0: t = 11'(c[5:0]);
			2'h1: t = 11'h040 + 11'(c[5:0]) * 11'h004;
			2'h2: t = 11'h140 + 11'(c[5:0]) * 11'h010;
			default: t = 11'h530;
		endcase
		if (c == 8'h00)
			t = dmin;
		else if (t < 11'h004)
			t = 11'h004;
		// slower of request and what the port can do
		if (t < pmin)
			t = pmin;
		return t;
	endfunction
	function automatic logic [127:0] swp(input logic [127:0] d, input int dsz, input int msz, input int sw);
		logic [127:0] r;
		int j;
		r = '0;
		for (int i = 0; i < msz; i++)
		begin
			case (sw)
				1: j = i ^ 1;
				2: j = ((i | 3) < msz) ? i ^ 3 : i;
				3: j = msz - 1 - i;
				default: j = i;
			endcase
			// padding beyond the device size swaps as zero data
			if (j < dsz)
				r[8*i +: 8] = d[8*j +: 8];
		end
		return r;
	endfunction
	////////////////////////////////////////////////////////////////////////
	task automatic s_reset();
		chk(128'(cycle_time), 128'h4);
		rdchk(ADDR_CTRL, 32'h10);
		rdchk(ADDR_CYCLE, 32'h0);
		rdchk(ADDR_VENDOR, 32'h1);
		rdchk(ADDR_DEVICE, 32'h1);
		rdchk(ADDR_SIZE, 32'h1010);
		rdchk(ADDR_LIMIT, 32'h00040004);
		rdchk(8'h20, 32'h0);
		chk(128'(err), 128'h1);
	endtask
	task automatic s_cycle();
		logic [7:0] codes [12] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h0a, 8'h3f, 8'h40, 8'h41, 8'h7f, 8'hbf, 8'hc0, 8'hff};
		apb(1'b1, ADDR_LIMIT, 32'h00040014);
		foreach (codes[k])
		begin
			apb(1'b1, ADDR_CYCLE, 32'(codes[k]));
			cur = cyc_exp(codes[k], 11'h014, 11'h004);
			start(2'h3);
		end
		apb(1'b1, ADDR_LIMIT, 32'h001e0004);
		apb(1'b1, ADDR_CYCLE, 32'h0a);
		chk(128'(cycle_time), 128'h530);
		cur = cyc_exp(8'h0a, 11'h004, 11'h01e);
		start(2'h3);
	endtask
	task automatic s_swap();
		for (int i = 0; i < 16; i++)
			set_pd[8*i +: 8] <= 8'(8'ha0 + i);
		apb(1'b1, ADDR_SIZE, 32'h100a);
		for (int sw = 0; sw < 4; sw++)
		begin
			apb(1'b1, ADDR_CTRL, 32'h10 | 32'(sw << 2));
			start(2'h3);
			chk(map_pd_in, swp(set_pd, 10, 16, sw));
		end
		apb(1'b1, ADDR_SIZE, 32'h0202);
		apb(1'b1, ADDR_CTRL, 32'h18);
		start(2'h3);
		chk(map_pd_in, swp(set_pd, 2, 2, 2));
	endtask
	task automatic s_fail();
		for (int fs = 0; fs < 3; fs++)
		begin
			apb(1'b1, ADDR_CTRL, 32'h10 | 32'(fs));
			upstream_ok <= 1'b1;
			up_process_output_valid <= {8{16'h5a3c}};
			start(2'h3);
			@(posedge pclk);
			chk(applied, {8{16'h5a3c}});
			upstream_ok <= 1'b0;
			up_process_output_valid <= {8{16'h1234}};
			// new setting must wait for the next start
			apb(1'b1, ADDR_CTRL, (fs == 2) ? 32'h10 : 32'h12);
			chk(port_process_output_valid, (fs == 1) ? {8{16'h5a3c}} : '0);
			chk(128'(process_output_valid), (fs == 2) ? 128'h0 : 128'h1);
		end
		chk(applied, '1);
		// a stopped port drops its outputs until the next start
		@(posedge pclk);
		port_stop <= 1'b1;
		@(posedge pclk);
		port_stop <= 1'b0;
		repeat (2) @(posedge pclk);
		#1;
		chk(map_pd_in, '0);
		chk(port_process_output_valid, '0);
	endtask
	task automatic s_ds();
		apb(1'b1, ADDR_CTRL, 32'h310);
		dev(16'h5, 1'b0);
		start(2'h1);
		rdchk(ADDR_DSCK, 32'h5);
		start(2'h0);
		dev(16'h6, 1'b0);
		start(2'h2);
		dev(16'h6, 1'b1);
		start(2'h1);
		apb(1'b1, ADDR_CTRL, 32'h410);
		start(2'h0);
		dev(16'h7, 1'b0);
		start(2'h2);
		dev(16'h6, 1'b0);
		start(2'h0);
		apb(1'b1, ADDR_VENDOR, 32'h2);
		start(2'h0);
		apb(1'b1, ADDR_CTRL, 32'h310);
		start(2'h1);
		apb(1'b1, ADDR_DEVICE, 32'h2);
		start(2'h1);
		for (int v = 0; v < 3; v++)
		begin
			apb(1'b1, ADDR_CTRL, 32'h10 | 32'(v << 8));
			start(2'h3);
		end
		apb(1'b1, ADDR_CTRL, 32'h320);
		rdchk(ADDR_CTRL, 32'h20);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	initial
	begin
		fails = 0;
		n_checks = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		upstream_ok = 1'b0;
		up_process_output_valid = '0;
		port_start = 1'b0;
		port_stop = 1'b0;
		set_pd = '0;
		set_ck = 16'h0;
		set_req = 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		#1;
		s_reset();
		s_cycle();
		s_swap();
		s_fail();
		s_ds();
		test_done();
	end
endmodule // testbench
`default_nettype wire
